//--- inc/pcrs_params.svh
// Functional notes
// - Program counter is 15 bits; low byte readable, bits 14..8 come from latch.
// - Every reset clears the whole program counter to zero.
// - Writing the low byte loads bits 14..8 from the latch simultaneously.
// - Direct call loads low byte and bits 10..8 from operand, 14..11 from latch.
// - Accumulator call loads low byte from accumulator, high bits from the latch.
// - Accumulator branch loads incremented address plus unsigned accumulator.
// - Offset jump loads incremented address plus signed operand.
// - Return stack holds sixteen 15-bit entries outside program and data space.
// - Calls and interrupt vectoring push; the three return kinds pop.
// - Pushes and pops never change the high latch.
// - With fault reset disabled the stack is circular; push 17 overwrites entry 0.
// - Overflow and underflow flags set whether or not fault reset is enabled.
// - Software writes the stack index, then reads or writes the selected entry.
// - Stack index is five bits so overflow and underflow can be represented.
// - Push increments index then writes; return reads entry then decrements.
// - Empty stack is index 0x1F; first push gives 0x00, return restores 0x1F.
// - With fault reset enabled, overflow or underflow resets and sets its flag.
// - Fault reset enable is bit 9 of configuration word two; one enables.
`ifndef PCRS_PARAMS_SVH
`define PCRS_PARAMS_SVH

// register indices; byte address is four times the index
`define PCRS_IDX_STACK_INDEX 16'h0FED
`define PCRS_IDX_STACK_LOW   16'h0FEE
`define PCRS_IDX_STACK_HIGH  16'h0FEF
`define PCRS_IDX_POWER_CTRL  16'h0096
`define PCRS_IDX_PC_LOW      16'h0002
`define PCRS_IDX_CONFIG2     16'h8008

// bus geometry
`define PCRS_ADDR_W          18
`define PCRS_DATA_W          32

// field positions
`define PCRS_POS_OVER_FLAG   7
`define PCRS_POS_UNDER_FLAG  6
`define PCRS_POS_FAULT_EN    9

// reset values
`define PCRS_RST_PC          15'h0000
`define PCRS_RST_INDEX       5'h1F
`define PCRS_RST_CONFIG2     14'h3FFF
`define PCRS_LAST_ENTRY      5'h0F
`define PCRS_INT_VECTOR      15'h0004

`endif

//--- inc/pcrs_pkg.sv
package pcrs_pkg;

    // operation presented by the instruction decoder each cycle
    typedef enum logic [3:0] {
        op_step,
        op_pcl_write,
        op_call,
        op_call_via_accumulator,
        op_branch_via_accumulator,
        op_offset_jump,
        op_plain_return,
        op_return_with_literal,
        op_interrupt_return,
        op_int_vector
    } pcrs_op_e;

    typedef logic [1:0] pcrs_resp_t;

    localparam pcrs_resp_t RESP_OKAY   = 2'h0;
    localparam pcrs_resp_t RESP_SLVERR = 2'h2;

endpackage : pcrs_pkg

//--- rtl/pcrs_stack_mem.sv
`timescale 1ns/10ps
// ----------------------------------------
// return stack storage
// ----------------------------------------
module pcrs_stack_mem #(
    parameter int unsigned DEPTH = 16,
    parameter int unsigned WIDTH = 15
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     arst_n,
    // write port
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data,
    // read port
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [WIDTH-1:0]         rd_data
);

    logic [WIDTH-1:0] entry_q [DEPTH];

    // flip-flop array; cleared so reads are never unknown
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                entry_q[i] <= '0;
            end
        end
        else if (wr_en)
        begin
            entry_q[wr_idx] <= wr_data;
        end
    end

    // combinational read of the selected entry
    assign rd_data = entry_q[rd_idx];

endmodule : pcrs_stack_mem

//--- rtl/pcrs_core.sv
`timescale 1ns/10ps
`include "pcrs_params.svh"
module pcrs_core #(
    parameter int unsigned STACK_DEPTH = 16,
    parameter int unsigned PC_WIDTH    = 15
) (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      arst_n,
    // decoder side
    input  wire logic                      op_valid,
    input  pcrs_pkg::pcrs_op_e             op_code,
    input  wire logic [10:0]               op_operand,
    input  wire logic [7:0]                accumulator,
    input  wire logic [7:0]                pcl_wdata,
    input  wire logic [6:0]                pc_high_latch,
    // core outputs
    output logic      [PC_WIDTH-1:0]       pc_out,
    output logic                           stack_fault_reset,
    // axi4-lite write address
    input  wire logic [`PCRS_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    // axi4-lite write data
    input  wire logic [`PCRS_DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // axi4-lite read address
    input  wire logic [`PCRS_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    // axi4-lite read data
    output logic [`PCRS_DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // index width and empty code are fixed to sixteen entries of fifteen bits
    if (STACK_DEPTH != 16 || PC_WIDTH != 15)
    begin : g_bad_size
        $error("pcrs_core supports only sixteen entries of fifteen bits");
    end

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [14:0]              pc_q;
    logic [14:0]              pc_d;
    logic [4:0]               sp_q;
    logic [4:0]               sp_d;
    logic                     over_q;
    logic                     under_q;
    logic                     fault_en_q;
    logic                     fault_rst_q;
    logic                     push;
    logic                     pop;
    logic                     over_evt;
    logic                     under_evt;
    logic                     fault;
    logic [4:0]               sp_push;
    logic [4:0]               sp_pop;
    logic [14:0]              ret_addr;
    logic [14:0]              pc_inc;
    logic                     mem_we;
    logic [3:0]               mem_idx;
    logic [14:0]              mem_wdata;
    logic [14:0]              tos;
    logic                     aw_hold_q;
    logic                     w_hold_q;
    logic [15:0]              aw_idx_q;
    logic [31:0]              w_data_q;
    logic [3:0]               w_strb_q;
    logic                     wr_fire;
    logic                     wr_hit;
    logic [15:0]              ar_idx;
    logic [31:0]              rd_word;
    logic                     rd_hit;
    logic                     sw_index_we;
    logic                     sw_low_we;
    logic                     sw_high_we;
    logic                     sw_pwr_we;
    logic                     sw_cfg_we;
    // power-up image of config word two; a bit select keeps the enable one bit wide
    localparam logic [13:0]   CFG2_RST = `PCRS_RST_CONFIG2;

    // ----------------------------------------
    // stack control decode
    // ----------------------------------------
    // push and pop sources
    assign push = op_valid && (op_code == pcrs_pkg::op_call ||
                  op_code == pcrs_pkg::op_call_via_accumulator ||
                  op_code == pcrs_pkg::op_int_vector);
    assign pop  = op_valid && (op_code == pcrs_pkg::op_plain_return ||
                  op_code == pcrs_pkg::op_return_with_literal ||
                  op_code == pcrs_pkg::op_interrupt_return);

    assign over_evt  = push && (sp_q == `PCRS_LAST_ENTRY);
    assign under_evt = pop && (sp_q == `PCRS_RST_INDEX);

    assign fault = (over_evt || under_evt) && fault_en_q;

    // circular stepping keeps the low four bits in range
    // empty code steps to entry zero and back
    always_comb
    begin
        sp_push = 5'h00;
        sp_pop  = `PCRS_RST_INDEX;
        if (sp_q != `PCRS_RST_INDEX)
        begin
            sp_push = {1'b0, sp_q[3:0] + 4'h1};
        end
        if (sp_q == `PCRS_RST_INDEX)
        begin
            sp_pop = {1'b0, sp_q[3:0] - 4'h1};
        end
        else if (sp_q != 5'h00)
        begin
            sp_pop = sp_q - 5'h01;
        end
    end

    assign pc_inc   = pc_q + 15'h0001;
    // interrupt vectoring resumes at the instruction it displaced
    assign ret_addr = (op_code == pcrs_pkg::op_int_vector) ? pc_q : pc_inc;

    // ----------------------------------------
    // program counter next value
    // ----------------------------------------
    always_comb
    begin
        pc_d = pc_q;
        if (op_valid)
        begin
            unique case (op_code)
                pcrs_pkg::op_step:
                    pc_d = pc_inc;
                pcrs_pkg::op_pcl_write:
                    pc_d = {pc_high_latch, pcl_wdata};
                // operand low eleven, latch upper four
                pcrs_pkg::op_call:
                    pc_d = {pc_high_latch[6:3], op_operand};
                pcrs_pkg::op_call_via_accumulator:
                    pc_d = {pc_high_latch, accumulator};
                pcrs_pkg::op_branch_via_accumulator:
                    pc_d = pc_inc + {7'h00, accumulator};
                pcrs_pkg::op_offset_jump:
                    pc_d = pc_inc + {{6{op_operand[8]}}, op_operand[8:0]};
                // return reads the entry before the index moves
                pcrs_pkg::op_plain_return,
                pcrs_pkg::op_return_with_literal,
                pcrs_pkg::op_interrupt_return:
                    pc_d = tos;
                pcrs_pkg::op_int_vector:
                    pc_d = `PCRS_INT_VECTOR;
            endcase
        end
        // fault reset clears the counter too
        if (fault)
        begin
            pc_d = `PCRS_RST_PC;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pc_q <= `PCRS_RST_PC;
        end
        else
        begin
            pc_q <= pc_d;
        end
    end

    assign pc_out = pc_q;

    // ----------------------------------------
    // stack index
    // ----------------------------------------
    // a software write in the same cycle as a core push or pop is dropped
    always_comb
    begin
        sp_d = sp_q;
        if (fault)
        begin
            sp_d = `PCRS_RST_INDEX;
        end
        else if (push)
        begin
            sp_d = sp_push;
        end
        else if (pop)
        begin
            sp_d = sp_pop;
        end
        else if (sw_index_we)
        begin
            sp_d = w_data_q[4:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sp_q <= `PCRS_RST_INDEX;
        end
        else
        begin
            sp_q <= sp_d;
        end
    end

    // ----------------------------------------
    // stack storage
    // ----------------------------------------
    // stack never writes the latch; only the counter is stored
    always_comb
    begin
        mem_we    = 1'b0;
        mem_idx   = sp_q[3:0];
        mem_wdata = tos;
        if (push && !fault)
        begin
            mem_we    = 1'b1;
            mem_idx   = sp_push[3:0];
            mem_wdata = ret_addr;
        end
        // byte writes to the selected entry
        else if (!push && !pop && (sw_low_we || sw_high_we))
        begin
            mem_we    = 1'b1;
            mem_wdata = sw_low_we ? {tos[14:8], w_data_q[7:0]} : {w_data_q[6:0], tos[7:0]};
        end
    end

    pcrs_stack_mem #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (PC_WIDTH)
    ) u_stack (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .wr_en   (mem_we),
        .wr_idx  (mem_idx),
        .wr_data (mem_wdata),
        .rd_idx  (sp_q[3:0]),
        .rd_data (tos)
    );

    // ----------------------------------------
    // flags and configuration
    // ----------------------------------------
    // flags set on every limit event
    // set wins over a clear; a zero written to the flag bit or power-on reset clears them
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            over_q  <= 1'b0;
            under_q <= 1'b0;
        end
        else
        begin
            if (over_evt)
                over_q <= 1'b1;
            else if (sw_pwr_we && !w_data_q[`PCRS_POS_OVER_FLAG])
                over_q <= 1'b0;
            if (under_evt)
                under_q <= 1'b1;
            else if (sw_pwr_we && !w_data_q[`PCRS_POS_UNDER_FLAG])
                under_q <= 1'b0;
        end
    end

    // enable bit survives the fault reset
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_en_q <= CFG2_RST[`PCRS_POS_FAULT_EN];
        end
        else if (sw_cfg_we)
        begin
            fault_en_q <= w_data_q[`PCRS_POS_FAULT_EN];
        end
    end

    // one-cycle reset request to the rest of the device
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_rst_q <= 1'b0;
        end
        else
        begin
            fault_rst_q <= fault;
        end
    end

    assign stack_fault_reset = fault_rst_q;

    // ----------------------------------------
    // axi4-lite write path
    // ----------------------------------------
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
    assign wr_fire       = aw_hold_q && w_hold_q;

    // address and data are captured independently, in either order
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_idx_q  <= 16'h0000;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[17:2];
            end
            else if (wr_fire)
            begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (wr_fire)
            begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // write decode; byte lane 0 carries every field but the enable bit
    assign sw_index_we = wr_fire && w_strb_q[0] && aw_idx_q == `PCRS_IDX_STACK_INDEX;
    assign sw_low_we   = wr_fire && w_strb_q[0] && aw_idx_q == `PCRS_IDX_STACK_LOW;
    assign sw_high_we  = wr_fire && w_strb_q[0] && aw_idx_q == `PCRS_IDX_STACK_HIGH;
    assign sw_pwr_we   = wr_fire && w_strb_q[0] && aw_idx_q == `PCRS_IDX_POWER_CTRL;
    assign sw_cfg_we   = wr_fire && w_strb_q[1] && aw_idx_q == `PCRS_IDX_CONFIG2;
    assign wr_hit      = aw_idx_q inside {`PCRS_IDX_STACK_INDEX, `PCRS_IDX_STACK_LOW,
                         `PCRS_IDX_STACK_HIGH, `PCRS_IDX_POWER_CTRL, `PCRS_IDX_PC_LOW,
                         `PCRS_IDX_CONFIG2};

    // response one cycle after both halves are held
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pcrs_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? pcrs_pkg::RESP_OKAY : pcrs_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // axi4-lite read path
    // ----------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_idx        = s_axi_araddr[17:2];

    // read mux; unused bits read zero, but the other bits 13..0 of config word two read one
    always_comb
    begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        unique case (ar_idx)
            `PCRS_IDX_STACK_INDEX: rd_word[4:0] = sp_q;
            `PCRS_IDX_STACK_LOW:   rd_word[7:0] = tos[7:0];
            `PCRS_IDX_STACK_HIGH:  rd_word[6:0] = tos[14:8];
            `PCRS_IDX_PC_LOW:      rd_word[7:0] = pc_q[7:0];
            `PCRS_IDX_POWER_CTRL:
            begin
                rd_word[`PCRS_POS_OVER_FLAG]  = over_q;
                rd_word[`PCRS_POS_UNDER_FLAG] = under_q;
            end
            `PCRS_IDX_CONFIG2:
            begin
                rd_word[13:0] = `PCRS_RST_CONFIG2;
                rd_word[`PCRS_POS_FAULT_EN] = fault_en_q;
            end
            default:               rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= pcrs_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? pcrs_pkg::RESP_OKAY : pcrs_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_op(pcrs_pkg::pcrs_op_e o);
        op_valid && op_code == o && !fault;
    endsequence

    sequence s_push_at_last;
        push && sp_q == `PCRS_LAST_ENTRY;
    endsequence

    pcl_load_a: assert property (s_op(pcrs_pkg::op_pcl_write) |=>
        pc_q == {$past(pc_high_latch), $past(pcl_wdata)})
        else $error("low byte write did not load latch bits");
    call_load_a: assert property (s_op(pcrs_pkg::op_call) |=>
        pc_q[10:0] == $past(op_operand) && pc_q[14:11] == $past(pc_high_latch[6:3]))
        else $error("direct call target wrong");
    acc_call_a: assert property (s_op(pcrs_pkg::op_call_via_accumulator) |=>
        pc_q == {$past(pc_high_latch), $past(accumulator)})
        else $error("accumulator call target wrong");
    acc_branch_a: assert property (s_op(pcrs_pkg::op_branch_via_accumulator) |=>
        pc_q == 15'($past(pc_q) + 15'h0001 + {7'h00, $past(accumulator)}))
        else $error("accumulator branch target wrong");
    offset_jump_a: assert property (s_op(pcrs_pkg::op_offset_jump) |=>
        pc_q == 15'($past(pc_q) + 15'h0001 + {{6{$past(op_operand[8])}}, $past(op_operand[8:0])}))
        else $error("offset jump target wrong");
    call_return_a: assert property (s_op(pcrs_pkg::op_call) ##1 !op_valid && !wr_fire
        ##1 s_op(pcrs_pkg::op_plain_return)
        |=> pc_q == $past(pc_q, 3) + 15'h0001 && sp_q == $past(sp_q, 3))
        else $error("call then return did not restore counter and index");
    empty_push_a: assert property (push && !fault && sp_q == `PCRS_RST_INDEX |=> sp_q == 5'h00)
        else $error("first push did not give index zero");
    wrap_push_a: assert property (s_push_at_last and !fault_en_q |=> sp_q == 5'h00 ##0 over_q)
        else $error("circular push did not wrap to entry zero");
    over_flag_a: assert property (s_push_at_last |=> over_q)
        else $error("overflow flag not set");
    fault_rst_a: assert property ((over_evt || under_evt) && fault_en_q |=>
        stack_fault_reset && pc_q == 15'h0000 && sp_q == `PCRS_RST_INDEX ##1 !stack_fault_reset)
        else $error("stack fault reset sequence wrong");
    flag_hold_a: assert property (over_q && !sw_pwr_we |=> over_q)
        else $error("overflow flag dropped without software clear");

endmodule : pcrs_core

//--- sim/pcrs_dec_model.sv
`timescale 1ns/10ps
// ----------------------------
// decoder partner model
// ----------------------------
module pcrs_dec_model (
    // clock
    input  wire logic          sys_clk,
    // operation to the core
    output logic               op_valid,
    output pcrs_pkg::pcrs_op_e op_code,
    output logic [10:0]        op_operand,
    output logic [7:0]         accumulator,
    output logic [7:0]         pcl_wdata
);
    // quiet until asked
    initial
    begin
        op_valid = 1'b0;
        op_code = pcrs_pkg::op_step;
        {op_operand, accumulator, pcl_wdata} = '0;
    end
    // one op; never during a bus write
    task automatic issue(input pcrs_pkg::pcrs_op_e c, input logic [10:0] o, input logic [7:0] a);
        @(posedge sys_clk);
        op_code <= c;
        {op_valid, op_operand, accumulator, pcl_wdata} <= {1'b1, o, a, a};
        @(posedge sys_clk);
        // inverted idle data so a stale sample cannot pass
        {op_valid, op_operand, accumulator, pcl_wdata} <= {1'b0, ~o, ~a, ~a};
    endtask : issue
endmodule : pcrs_dec_model

//--- sim/program_counter_and_return_stack_tb_top.sv
`timescale 1ns/10ps
`include "pcrs_params.svh"
// ----------------------------
// bench top
// ----------------------------
module program_counter_and_return_stack_tb_top;
    localparam logic [17:0] AIX = `PCRS_IDX_STACK_INDEX * 4;
    localparam logic [17:0] ALO = `PCRS_IDX_STACK_LOW * 4;
    localparam logic [17:0] AHI = `PCRS_IDX_STACK_HIGH * 4;
    localparam logic [17:0] APW = `PCRS_IDX_POWER_CTRL * 4;
    localparam logic [17:0] ACF = `PCRS_IDX_CONFIG2 * 4;
    logic sys_clk = 1'b0, arst_n = 1'b0, op_valid, stack_fault_reset, s_axi_awvalid, s_axi_wvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    pcrs_pkg::pcrs_op_e op_code, c;
    logic [10:0] op_operand;
    logic [7:0] accumulator, pcl_wdata;
    logic [6:0] pc_high_latch = 7'h00;
    logic [14:0] pc_out, p, q[$];
    int failures, total_checks, i, seed = 54969;
    // 100 ns clock
    always #50 sys_clk = ~sys_clk;
    // core and its decoder
    pcrs_core dut (.sys_clk, .arst_n, .op_valid, .op_code, .op_operand, .accumulator, .pcl_wdata,
        .pc_high_latch, .pc_out, .stack_fault_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    pcrs_dec_model dec (.sys_clk, .op_valid, .op_code, .op_operand, .accumulator, .pcl_wdata);
    // verdict
    task automatic stop_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // one bus transfer, a read when w is low; handshakes sampled at the half cycle
    task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] wd, input logic [3:0] s);
        logic aw, wr, ar, dn;
        dn = 1'b0;
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, wd, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
        for (int n = 0; n < 40 && !dn; n++)
        begin
            @(negedge sys_clk);
            {aw, wr, ar} = {s_axi_awready, s_axi_wready, s_axi_arready};
            dn = w ? s_axi_bvalid : s_axi_rvalid;
            r = w ? s_axi_bresp : s_axi_rresp;
            d = s_axi_rdata;
            @(posedge sys_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (wr) s_axi_wvalid <= 1'b0;
            if (ar) s_axi_arvalid <= 1'b0;
            if (dn) {s_axi_bready, s_axi_rready} <= 2'b00;
        end
        if (!dn)
        begin
            failures++;
            stop_test();
        end
    endtask : bus
    // expected counter for the non-return ops
    function automatic logic [14:0] nx(pcrs_pkg::pcrs_op_e c, logic [10:0] o, logic [7:0] a);
        case (c)
            pcrs_pkg::op_step: return p + 15'd1;
            pcrs_pkg::op_call: return {pc_high_latch[6:3], o};
            pcrs_pkg::op_pcl_write, pcrs_pkg::op_call_via_accumulator: return {pc_high_latch, a};
            pcrs_pkg::op_branch_via_accumulator: return p + 15'd1 + 15'(a);
            pcrs_pkg::op_offset_jump: return p + 15'd1 + 15'($signed(o[8:0]));
            pcrs_pkg::op_int_vector: return `PCRS_INT_VECTOR;
            default: return p;
        endcase
    endfunction : nx
    // issue one op and track the stack
    task automatic op(input pcrs_pkg::pcrs_op_e c, input logic [10:0] o, input logic [7:0] a);
        logic [14:0] e;
        dec.issue(c, o, a);
        e = nx(c, o, a);
        if (c inside {pcrs_pkg::op_call, pcrs_pkg::op_call_via_accumulator}) q.push_back(p + 15'd1);
        if (c == pcrs_pkg::op_int_vector) q.push_back(p);
        if (c >= pcrs_pkg::op_plain_return && c <= pcrs_pkg::op_interrupt_return) e = q.pop_back();
        #1 chk("pc", 32'(e), 32'(pc_out));
        p = e;
    endtask : op
    // main sequence
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, p} = '0;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        #1 chk("pc", 0, 32'(pc_out));
        bus(0, AIX, 0, 0); chk("idx", 32'h1F, d);
        op(pcrs_pkg::op_call, 11'h5A3, 0);
        bus(0, AIX, 0, 0); chk("idx", 0, d);
        bus(0, AHI, 0, 0); chk("stack_top_high", 32'(q[0][14:8]), d);
        bus(1, ALO, 32'hC3, 4'h1); chk("resp", pcrs_pkg::RESP_OKAY, 32'(r));
        q[0][7:0] = 8'hC3;
        op(pcrs_pkg::op_plain_return, 0, 0);
        bus(0, AIX, 0, 0); chk("idx", 32'h1F, d);
        op(pcrs_pkg::op_call, 11'h2B4, 0);
        op(pcrs_pkg::op_plain_return, 0, 0);
        // random mix, depth kept inside the stack
        for (i = 0; i < 80; i++)
        begin
            pc_high_latch <= 7'($random(seed));
            c = pcrs_pkg::pcrs_op_e'($unsigned($random(seed)) % 10);
            if (q.size() == 0) c = pcrs_pkg::op_int_vector;
            if (q.size() > 14) c = pcrs_pkg::op_interrupt_return;
            op(c, 11'($random(seed)), 8'($random(seed)));
        end
        while (q.size() > 0) op(pcrs_pkg::op_return_with_literal, 0, 0);
        // seventeenth push and an empty pop both trip the fault reset
        for (i = 0; i < 16; i++) op(pcrs_pkg::op_call_via_accumulator, 0, 8'(i));
        dec.issue(pcrs_pkg::op_call, 11'h7FF, 0);
        #1 chk("sfr", 1, 32'(stack_fault_reset));
        chk("pc", 0, 32'(pc_out));
        bus(0, APW, 0, 0); chk("flags", 2'b10, 32'(d[7:6]));
        bus(1, APW, 0, 4'h1);
        dec.issue(pcrs_pkg::op_plain_return, 0, 0);
        #1 chk("sfr", 1, 32'(stack_fault_reset));
        bus(0, APW, 0, 0); chk("flags", 2'b01, 32'(d[7:6]));
        // fault reset off: circular stack
        bus(1, ACF, 0, 4'h2);
        bus(0, ACF, 0, 0); chk("cfg", 32'h3DFF, d);
        p = '0;
        q.delete();
        for (i = 0; i < 17; i++) op(pcrs_pkg::op_call, 11'(i * 3), 0);
        bus(0, AIX, 0, 0); chk("idx", 0, d);
        bus(0, ALO, 0, 0); chk("stack_top_low", 32'(q[16][7:0]), d);
        bus(0, APW, 0, 0); chk("ovf", 1, 32'(d[7]));
        bus(0, 18'h00004, 0, 0); chk("resp", pcrs_pkg::RESP_SLVERR, 32'(r));
        stop_test();
    end
endmodule : program_counter_and_return_stack_tb_top
